// file: dv/mit_core_tb.sv
/*
 * Self-checking bench for mit_core: drives instruction words and data values,
 * judges cycle counts and results. Assumes mit_pkg and its header compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module mit_core_tb;
import mit_pkg::*;
logic mclk;
logic rst_b;
logic [15:0] instr;
logic [7:0] mem_rdata;
logic [12:0] fetch_addr;
mit_mem_s mem_out;
logic [7:0] acc;
mit_flags_s flags;
logic cycle_end;
int fail_count;
int checks_done;
int n;
logic [12:0] pc_x;
logic [12:0] resume_x;
logic [7:0] imm_x;
mit_mem_s mem_q;

mit_core i_mit_core
(
    .mclk(mclk),
    .rst_b(rst_b),
    .instr(instr),
    .mem_rdata(mem_rdata),
    .fetch_addr(fetch_addr),
    .mem_out(mem_out),
    .acc(acc),
    .flags(flags),
    .cycle_end(cycle_end)
);

initial
begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
end

task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask

task automatic ck(input string s, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("FAIL %s expected %h seen %h", s, exp, seen);
    end
endtask

task automatic hang_check;
    if (n >= 20)
    begin
        fail_count++;
        end_of_test();
    end
endtask

// Counts edges up to the next cycle end and keeps the write seen there.
task automatic wait_ce;
    n = 0;
    do
    begin
        @(posedge mclk);
        #1;
        n++;
    end while (cycle_end !== 1'b1 && n < 20);
    hang_check();
    mem_q = mem_out;
endtask

task automatic issue(input logic [15:0] w, input logic [7:0] rd);
    @(posedge mclk);
    instr <= w;
    mem_rdata <= rd;
    wait_ce();
    pc_x = pc_x + 13'h1;
    ck("clocks", 16'(n), 16'h3);
endtask

// Loads a fresh immediate; n ends as the edge count until it lands.
task automatic mark;
    imm_x = imm_x + 8'h1;
    @(posedge mclk);
    instr <= {8'h01, imm_x};
    n = 0;
    do
    begin
        @(posedge mclk);
        #1;
        n++;
    end while (acc !== imm_x && n < 20);
    hang_check();
    pc_x = pc_x + 13'h1;
endtask

task automatic t_reset;
    repeat (20) @(posedge mclk);
    ck("rst_acc", {acc, 6'h0, flags}, 16'h0);
    ck("rst_pc", {1'h0, mem_out.we, cycle_end, fetch_addr}, 16'h0);
    rst_b <= 1'b1;
    wait_ce();
    pc_x = 13'h1;
    ck("first", 16'(n), 16'h4);
    ck("imm", {8'h0, acc}, 16'hf0);
endtask

task automatic t_move;
    issue(16'h0033, 8'h3c);
    ck("ld", {8'h0, acc}, 16'h3c);
    issue(16'h0244, 8'h00);
    ck("st", {mem_q.addr[6:0], mem_q.we, mem_q.wdata}, {7'h44, 1'h1, 8'h3c});
endtask

task automatic t_arith;
    issue(16'h01f0, 8'h00);
    issue(16'h1020, 8'h20);
    ck("add", {6'h0, flags, acc}, {6'h0, 2'h1, 8'h10});
    issue(16'h1100, 8'hff);
    ck("add_c", {6'h0, flags, acc}, {6'h0, 2'h1, 8'h10});
    issue(16'h1200, 8'h20);
    ck("sub", {6'h0, flags, acc}, {6'h0, 2'h0, 8'hf0});
    issue(16'h1b77, 8'hf0);
    ck("subc_m", {mem_q.addr[6:0], mem_q.we, mem_q.wdata}, {7'h77, 1'h1, 8'hff});
    ck("subc_f", {6'h0, flags, acc}, {6'h0, 2'h0, 8'hf0});
    issue(16'h4200, 8'h03);
    ck("rot_r_c", {7'h0, flags.carry, acc}, 16'h0101);
    issue(16'h4300, 8'h40);
    ck("rot_l_c", {7'h0, flags.carry, acc}, 16'h0081);
    issue(16'h4000, 8'h81);
    ck("rot_r", {7'h0, flags.carry, acc}, 16'h00c0);
    issue(16'h4100, 8'h81);
    ck("rot_l", {7'h0, flags.carry, acc}, 16'h0003);
endtask

task automatic t_logic;
    issue(16'h01f0, 8'h00);
    issue(16'h2000, 8'h0f);
    ck("and", {7'h0, flags.zero, acc}, 16'h0100);
    issue(16'h2100, 8'h0f);
    ck("or", {7'h0, flags.zero, acc}, 16'h000f);
    issue(16'h2200, 8'h0f);
    ck("xor", {7'h0, flags.zero, acc}, 16'h0100);
    issue(16'h2300, 8'hf0);
    ck("compl", {7'h0, flags.zero, acc}, 16'h000f);
    issue(16'h2b55, 8'h5a);
    ck("compl_m", {mem_q.addr[6:0], mem_q.we, mem_q.wdata}, {7'h55, 1'h1, 8'ha5});
endtask

task automatic t_incdec;
    issue(16'h3000, 8'hff);
    ck("incr_acc", {8'h0, acc}, 16'h0000);
    issue(16'h3100, 8'h00);
    ck("decr_acc", {8'h0, acc}, 16'h00ff);
    issue(16'h3921, 8'h00);
    ck("decr_m", {mem_q.addr[6:0], mem_q.we, mem_q.wdata}, {7'h21, 1'h1, 8'hff});
endtask

task automatic t_bits;
    issue(16'h6b12, 8'ha5);
    ck("set", {mem_q.addr[6:0], mem_q.we, mem_q.wdata}, {7'h12, 1'h1, 8'had});
    issue(16'h6013, 8'ha5);
    ck("clr", {mem_q.addr[6:0], mem_q.we, mem_q.wdata}, {7'h13, 1'h1, 8'ha4});
endtask

task automatic t_skip;
    issue(16'h5000, 8'h05);
    mark();
    ck("noskip", 16'(n), 16'h3);
    issue(16'h5000, 8'h00);
    pc_x = pc_x + 13'h1;
    mark();
    ck("skip", 16'(n), 16'h7);
    ck("skip_pc", {3'h0, fetch_addr}, {3'h0, pc_x});
    issue(16'h5d00, 8'h20);
    pc_x = pc_x + 13'h1;
    mark();
    ck("bskip", 16'(n), 16'h7);
    issue(16'h5a00, 8'h04);
    mark();
    ck("bnoskip", 16'(n), 16'h3);
    ck("bn_pc", {3'h0, fetch_addr}, {3'h0, pc_x});
endtask

task automatic t_branch;
    issue(16'h7040, 8'h00);
    ck("jump_pc", {3'h0, fetch_addr}, 16'h0040);
    pc_x = 13'h40;
    mark();
    ck("jump", 16'(n), 16'h7);
    resume_x = pc_x + 13'h1;
    issue(16'h8080, 8'h00);
    pc_x = 13'h80;
    mark();
    ck("call", 16'(n), 16'h7);
    issue(16'h70c0, 8'h00);
    pc_x = 13'hc0;
    mark();
    issue(16'h9000, 8'h00);
    ck("return_pc", {3'h0, fetch_addr}, {3'h0, resume_x});
    pc_x = resume_x;
    mark();
    ck("return", 16'(n), 16'h7);
    issue(16'ha000, 8'h00);
    mark();
    ck("table", 16'(n), 16'h7);
endtask

task automatic t_pc_low;
    issue(16'h0130, 8'h00);
    issue(16'h0206, 8'h00);
    pc_x = 13'h30;
    mark();
    ck("pc_low", 16'(n), 16'h7);
    ck("pc_low_pc", {3'h0, fetch_addr}, {3'h0, pc_x});
endtask

initial
begin
    rst_b = 1'b0;
    instr = 16'h01f0;
    mem_rdata = 8'h00;
    fail_count = 0;
    checks_done = 0;
    pc_x = 13'h0;
    resume_x = 13'h0;
    imm_x = 8'h60;
    t_reset();
    t_move();
    t_arith();
    t_logic();
    t_incdec();
    t_bits();
    t_skip();
    t_branch();
    t_pc_low();
    end_of_test();
end
endmodule
`default_nettype wire

// file: verilog/mit_core.sv
/*
 * Instruction sequencer and datapath of a small 8-bit core.
 * Assumes an instruction word and the data memory read value arrive from logic on mclk
 * and stay stable through the instruction cycle.
 */
// Function
// - Four clocks per cycle, ordinary instruction one
// - Jump, call, table read take two
// - Returns take one extra cycle
// - Writing program counter low byte jumps, extra
// - Skip costs extra cycle only when taken
// - Moves: memory-to-acc, acc-to-memory, immediate
// - Add carries above 255, subtract borrows
// - Increment or decrement by one, selectable destination
// - Logic results of zero set zero flag
// - Rotate one bit, optionally through carry
// - Call saves return address, jump does not
// - Conditional tests skip next instruction
// - Bit set/clear keeps other bits
`timescale 1ns/1ns
`default_nettype none
`include "mit_params.svh"

module mit_core
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] instr,
    input wire logic [7:0] mem_rdata,
    output logic [12:0] fetch_addr,
    output mit_pkg::mit_mem_s mem_out,
    output logic [7:0] acc,
    output mit_pkg::mit_flags_s flags,
    output logic cycle_end
);
    import mit_pkg::*;

    // Instruction word: [15:12] class, [11:8] sub-op, [10:8] bit index, [7:0] operand.
    // Sub-op bit 3 selects memory destination, bit 2 sets the tested-bit polarity of a bit skip where relevant.

    mit_state_s s_q;
    mit_state_s s_d;

    function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    mit_op_e op;
    logic [3:0] sub;
    logic [7:0] opnd;
    logic [2:0] bidx;
    logic [7:0] res;
    logic [8:0] wide;
    logic to_mem;
    logic skip_take;
    logic extra;
    logic [12:0] target;
    logic [2:0] sp_dn;

    assign op = mit_op_e'(instr[`MIT_OP_MSB:`MIT_OP_LSB]);
    assign sub = instr[`MIT_SUB_MSB:`MIT_SUB_LSB];
    assign bidx = instr[`MIT_BIT_MSB:`MIT_BIT_LSB];
    assign opnd = instr[7:0];

    always_comb
    begin
        s_d = s_q;
        res = s_q.acc;
        wide = 9'h000;
        to_mem = 1'b0;
        skip_take = 1'b0;
        extra = 1'b0;
        target = {s_q.pc[12:8], 8'h00};
        // The stack pointer wraps in three bits, so an empty stack pops the top slot.
        sp_dn = s_q.sp - 3'h1;
        s_d.mem.we = 1'b0;
        s_d.cycle_end = 1'b0;
        s_d.phase = s_q.phase + 2'h1;
        if (s_q.phase == `MIT_PHASE_LAST)
        begin
            s_d.cycle_end = 1'b1;
            if (s_q.state == MIT_ST_EXTRA)
            begin
                // Refill cycle: the prefetched word is dropped, nothing else moves.
                s_d.state = MIT_ST_EXEC;
                s_d.fetch = s_q.pc;
            end
            else
            begin
                case (op)
                    MIT_OP_MOVE:
                    begin
                        case (sub[1:0])
                            2'h0: res = mem_rdata;
                            2'h1: res = opnd;
                            default:
                            begin
                                res = s_q.acc;
                                to_mem = 1'b1;
                            end
                        endcase
                    end
                    MIT_OP_ARITH:
                    begin
                        if (sub[1])
                            wide = add9(s_q.acc, ~mem_rdata, ~sub[0] | s_q.flags.carry);
                        else
                            wide = add9(s_q.acc, mem_rdata, sub[0] & s_q.flags.carry);
                        res = wide[7:0];
                        s_d.flags.carry = wide[8];
                        s_d.flags.zero = (res == 8'h00);
                        to_mem = sub[3];
                    end
                    MIT_OP_LOGIC:
                    begin
                        case (sub[1:0])
                            2'h0: res = s_q.acc & mem_rdata;
                            2'h1: res = s_q.acc | mem_rdata;
                            2'h2: res = s_q.acc ^ mem_rdata;
                            default: res = ~mem_rdata;
                        endcase
                        s_d.flags.zero = (res == 8'h00);
                        to_mem = sub[3];
                    end
                    MIT_OP_INCDEC:
                    begin
                        res = sub[0] ? mem_rdata - 8'h01 : mem_rdata + 8'h01;
                        s_d.flags.zero = (res == 8'h00);
                        to_mem = sub[3];
                    end
                    MIT_OP_ROTATE:
                    begin
                        case (sub[1:0])
                            2'h0: res = {mem_rdata[0], mem_rdata[7:1]};
                            2'h1: res = {mem_rdata[6:0], mem_rdata[7]};
                            2'h2:
                            begin
                                res = {s_q.flags.carry, mem_rdata[7:1]};
                                s_d.flags.carry = mem_rdata[0];
                            end
                            default:
                            begin
                                res = {mem_rdata[6:0], s_q.flags.carry};
                                s_d.flags.carry = mem_rdata[7];
                            end
                        endcase
                        to_mem = sub[3];
                    end
                    MIT_OP_SKIP:
                    begin
                        if (sub[3])
                            skip_take = ~mem_rdata[bidx] ^ sub[2];
                        else
                            skip_take = (mem_rdata == 8'h00);
                        extra = skip_take;
                    end
                    MIT_OP_BITSC:
                    begin
                        res = mem_rdata;
                        res[bidx] = sub[3];
                        to_mem = 1'b1;
                    end
                    MIT_OP_JUMP:
                    begin
                        target = {s_q.pc[12:8], opnd};
                        extra = 1'b1;
                    end
                    MIT_OP_CALL:
                    begin
                        target = {s_q.pc[12:8], opnd};
                        extra = 1'b1;
                        s_d.stack[s_q.sp*13 +: 13] = s_q.pc + 13'h0001;
                        s_d.sp = s_q.sp + 3'h1;
                    end
                    MIT_OP_RETURN:
                    begin
                        target = s_q.stack[sp_dn*13 +: 13];
                        s_d.sp = sp_dn;
                        extra = 1'b1;
                    end
                    MIT_OP_TABLE:
                    begin
                        res = mem_rdata;
                        extra = 1'b1;
                    end
                    default:
                    begin
                        res = s_q.acc;
                    end
                endcase
                if (op inside {MIT_OP_MOVE, MIT_OP_ARITH, MIT_OP_LOGIC, MIT_OP_INCDEC,
                               MIT_OP_ROTATE, MIT_OP_BITSC})
                begin
                    if (to_mem)
                    begin
                        s_d.mem.we = 1'b1;
                        s_d.mem.addr = opnd;
                        s_d.mem.wdata = res;
                        if (opnd == `MIT_PC_LOW_ADDR)
                        begin
                            target = {s_q.pc[12:8], res};
                            extra = 1'b1;
                        end
                    end
                    else if (op != MIT_OP_BITSC)
                        s_d.acc = res;
                end
                else if (op == MIT_OP_TABLE)
                    s_d.acc = res;
                if (extra)
                begin
                    s_d.state = MIT_ST_EXTRA;
                    if (op == MIT_OP_SKIP)
                        s_d.pc = s_q.pc + 13'h0002;
                    else
                        s_d.pc = target;
                    s_d.fetch = s_d.pc;
                end
                else
                begin
                    s_d.pc = s_q.pc + 13'h0001;
                    s_d.fetch = s_d.pc;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '{state: MIT_ST_EXEC, phase: 2'h0, pc: `MIT_PC_RESET,
                     acc: `MIT_ACC_RESET, flags: '0, mem: '0, fetch: `MIT_PC_RESET,
                     cycle_end: 1'b0, sp: 3'h0, stack: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign fetch_addr = s_q.fetch;
    assign mem_out = s_q.mem;
    assign acc = s_q.acc;
    assign flags = s_q.flags;
    assign cycle_end = s_q.cycle_end;

    sequence cyc_start_s;
        s_q.cycle_end;
    endsequence

    cycle_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
        cyc_start_s |=> !s_q.cycle_end [*3] ##1 s_q.cycle_end)
        else $error("cycle not four clocks");

    extra_nop_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.state == MIT_ST_EXTRA) |=> $stable(s_q.acc) && $stable(s_q.flags))
        else $error("refill cycle changed state");

    jump_two_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_JUMP)
        |=> s_q.state == MIT_ST_EXTRA && s_q.pc[7:0] == $past(opnd)
            && s_q.pc[12:8] == $past(s_q.pc[12:8]))
        else $error("jump did not take two cycles");

    jump_nosave_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_JUMP)
        |=> $stable(s_q.sp))
        else $error("jump touched the return stack");

    return_extra_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_RETURN)
        |=> s_q.state == MIT_ST_EXTRA)
        else $error("return lacked extra cycle");

    skip_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_SKIP && !skip_take)
        |=> s_q.state == MIT_ST_EXEC && s_q.pc == $past(s_q.pc) + 13'h0001)
        else $error("untaken skip cost extra");

    zero_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_LOGIC && !sub[3])
        |=> s_q.flags.zero == (s_q.acc == 8'h00))
        else $error("zero flag wrong");

    bit_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_BITSC)
        |=> s_q.mem.we && ((s_q.mem.wdata ^ $past(mem_rdata)) & ~(8'h01 << $past(bidx))) == 8'h00)
        else $error("bit op touched other bits");

    incdec_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.phase == 2'h3 && s_q.state == MIT_ST_EXEC && op == MIT_OP_INCDEC && !sub[3]
         && !sub[0]) |=> s_q.acc == $past(mem_rdata) + 8'h01)
        else $error("increment not by one");

endmodule

`default_nettype wire

// file: verilog/mit_params.svh
/*
 * Timing and field constants for the instruction timing core.
 * Assumes inclusion by the package and the core; definitions only.
 */
`ifndef MIT_PARAMS_SVH
`define MIT_PARAMS_SVH

`define MIT_CLK_PERIOD_NS 40
`define MIT_PHASES_PER_CYCLE 4
`define MIT_PHASE_LAST 2'h3
`define MIT_ACC_RESET 8'h00
`define MIT_PC_RESET 13'h0000
`define MIT_PC_LOW_ADDR 8'h06
`define MIT_STACK_DEPTH 8
`define MIT_OP_LSB 12
`define MIT_OP_MSB 15
`define MIT_SUB_LSB 8
`define MIT_SUB_MSB 11
`define MIT_BIT_LSB 8
`define MIT_BIT_MSB 10

`endif

// file: verilog/mit_pkg.sv
/*
 * Types for the instruction timing core.
 * Assumes the constants header is on the include path.
 */
`include "mit_params.svh"

package mit_pkg;

    typedef enum logic [3:0] {
        MIT_OP_MOVE,
        MIT_OP_ARITH,
        MIT_OP_LOGIC,
        MIT_OP_INCDEC,
        MIT_OP_ROTATE,
        MIT_OP_SKIP,
        MIT_OP_BITSC,
        MIT_OP_JUMP,
        MIT_OP_CALL,
        MIT_OP_RETURN,
        MIT_OP_TABLE,
        MIT_OP_NOP
    } mit_op_e;

    typedef enum logic [1:0] {
        MIT_ST_EXEC,
        MIT_ST_EXTRA
    } mit_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
    } mit_mem_s;

    typedef struct packed {
        logic zero;
        logic carry;
    } mit_flags_s;

    typedef struct packed {
        mit_state_e state;
        logic [1:0] phase;
        logic [12:0] pc;
        logic [7:0] acc;
        mit_flags_s flags;
        mit_mem_s mem;
        logic [12:0] fetch;
        logic cycle_end;
        logic [2:0] sp;
        logic [103:0] stack;
    } mit_state_s;

endpackage
